// [include/ths_pkg.sv]
// Constants and types shared by the sensor I2C target logic.
package ths_pkg;
  localparam logic [6:0]  DEV_ADDR7   = 7'h5c;
  localparam logic [7:0]  FC_READ     = 8'h03;
  localparam logic [7:0]  FC_WRITE    = 8'h10;
  localparam logic [7:0]  FC_MAX      = 8'h7f;
  localparam logic [7:0]  FC_ERR_FLAG = 8'h80;
  localparam logic [7:0]  ERR_CODE    = 8'h01;
  localparam logic [7:0]  MAX_REGS    = 8'h0a;
  localparam logic [7:0]  RQ_HDR_B    = 8'h03;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;
  localparam int          REG_N       = 32;
  localparam logic [3:0]  BIT_ACK     = 4'h8;
  localparam logic [4:0]  RQ_FC       = 5'h00;
  localparam logic [4:0]  RQ_SA       = 5'h01;
  localparam logic [4:0]  RQ_CNT      = 5'h02;
  localparam logic [4:0]  RQ_HDR      = 5'h03;
  localparam logic [4:0]  RS_B1       = 5'h01;
  localparam logic [4:0]  RS_B2       = 5'h02;
  localparam logic [4:0]  RS_RD_HDR   = 5'h02;
  localparam logic [4:0]  RS_WR_LEN   = 5'h03;
  localparam logic [4:0]  RS_ERR_LEN  = 5'h02;
  localparam logic [4:0]  IDX_MAX     = 5'h1f;
  localparam int          RH_HI       = 0;
  localparam int          RH_LO       = 1;
  localparam int          TP_HI       = 2;
  localparam int          TP_LO       = 3;
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned TMO_S       = 3;
  localparam int unsigned TMO_CYC     = TMO_S * CLK_HZ;

  typedef enum logic [1:0] {
    SN_SLEEP = 2'b00,
    SN_AWAKE = 2'b01,
    SN_MEAS  = 2'b10
  } ths_pwr_e;

  typedef enum logic [2:0] {
    XF_IDLE = 3'b000,
    XF_ADDR = 3'b001,
    XF_WR   = 3'b010,
    XF_RD   = 3'b011,
    XF_SKIP = 3'b100
  } ths_xfer_e;
endpackage : ths_pkg

// [include/ths_bus_if.sv]
// Bus line events passed from the pin front end to the protocol core.
`timescale 1ns/1ns
`default_nettype none
interface ths_bus_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start_det;
  logic stop_det;
  modport fe (output scl_rise, scl_fall, sda, start_det, stop_det);
  modport core (input scl_rise, scl_fall, sda, start_det, stop_det);
endinterface : ths_bus_if
`default_nettype wire

// [rtl/ths_edges.sv]
// Pin synchroniser and start, stop and clock edge detector.
`timescale 1ns/1ns
`default_nettype none
module ths_edges
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl_i,
  input  wire logic sda_i,
  ths_bus_if.fe     bus
);
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  // Only the second stage and its delayed copy are looked at.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus.scl_rise  <= 1'b0;
      bus.scl_fall  <= 1'b0;
      bus.sda       <= 1'b1;
      bus.start_det <= 1'b0;
      bus.stop_det  <= 1'b0;
    end
    else
    begin
      bus.scl_rise  <= scl_s_r[1] & ~scl_d_r;
      bus.scl_fall  <= ~scl_s_r[1] & scl_d_r;
      bus.sda       <= sda_s_r[1];
      bus.start_det <= scl_s_r[1] & scl_d_r & ~sda_s_r[1] & sda_d_r;
      bus.stop_det  <= scl_s_r[1] & scl_d_r & sda_s_r[1] & ~sda_d_r;
    end
  end
endmodule : ths_edges
`default_nettype wire

// [rtl/ths_crc16.sv]
// One byte step of the reflected CRC-16.
`timescale 1ns/1ns
`default_nettype none
module ths_crc16
  import ths_pkg::*;
(
  input  wire logic [15:0] crc_i,
  input  wire logic [7:0]  byte_i,
  output logic      [15:0] crc_o
);
  always_comb
  begin
    crc_o = crc_i ^ {8'h00, byte_i};
    for (int i = 0; i < 8; i++)
    begin
      if (crc_o[0])
        crc_o = (crc_o >> 1) ^ CRC_POLY;
      else
        crc_o = crc_o >> 1;
    end
  end
endmodule : ths_crc16
`default_nettype wire

// [rtl/ths_i2c_target.sv]
// I2C target with the function-code register protocol and sleep control.
`timescale 1ns/1ns
`default_nettype none
module ths_i2c_target
  import ths_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = TMO_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             awake,
  output logic             meas_start,
  input  wire logic        meas_done,
  input  wire logic [15:0] meas_rh,
  input  wire logic [15:0] meas_temp
);
  localparam int TW = $clog2(TMO_CYCLES + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYCLES - 1);

  logic [1:0]    rst_s_r;
  logic          rst_sync_n;
  ths_pwr_e      pwr_r;
  ths_xfer_e     xf_r;
  logic [3:0]    bitcnt_r;
  logic          ackph_r;
  logic          nack_r;
  logic [7:0]    sh_r;
  logic [7:0]    tx_r;
  logic          sda_oe_r;
  logic          sda_o_r;
  logic          awake_r;
  logic          meas_start_r;
  logic          rd_sent_r;
  logic [7:0]    fc_r;
  logic [7:0]    sa_r;
  logic [7:0]    cnt_r;
  logic [4:0]    rx_idx_r;
  logic [4:0]    tx_idx_r;
  logic [15:0]   crc_r;
  logic [15:0]   crc_step;
  logic [TW-1:0] tmo_r;
  logic [7:0]    mem_r [REG_N];
  logic [7:0]    rsp_byte;
  logic [4:0]    rsp_len;
  logic          byte_done;
  logic          ack_fall;
  logic          addr_hit;
  logic          addr_rd;
  logic          ack_now;
  logic          load_tx;
  logic          tmo_hit;
  logic          fc_legal;
  logic          req_rd_ok;
  logic          req_wr_ok;
  logic          wr_data;
  logic [4:0]    wr_idx;

  ths_bus_if bus ();

  // Reset is released through two flops so all logic leaves it together.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_s_r <= 2'h0;
    else
      rst_s_r <= {rst_s_r[0], 1'b1};
  end
  assign rst_sync_n = rst_s_r[1];

  ths_edges u_edges
  (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .bus   (bus.fe)
  );

  ths_crc16 u_crc
  (
    .crc_i  (crc_r),
    .byte_i (rsp_byte),
    .crc_o  (crc_step)
  );

  // A byte is eight clocked bits; the ninth clock carries the ack.
  assign byte_done = bus.scl_fall && !ackph_r && bitcnt_r == BIT_ACK;
  assign ack_fall  = bus.scl_fall && ackph_r;
  assign addr_hit  = sh_r[7:1] == DEV_ADDR7;
  assign addr_rd   = sh_r[0];
  assign tmo_hit   = pwr_r == SN_AWAKE && tmo_r == TMO_LAST;
  assign load_tx   = xf_r == XF_RD && !nack_r;

  // A wake-up access while asleep is deliberately not acknowledged.
  assign ack_now = (xf_r == XF_ADDR && pwr_r == SN_AWAKE && addr_hit)
                || xf_r == XF_WR;

  assign fc_legal  = fc_r != 8'h00 && fc_r <= FC_MAX;
  assign req_rd_ok = fc_legal && fc_r == FC_READ && rx_idx_r >= RQ_HDR
                  && cnt_r != 8'h00 && cnt_r <= MAX_REGS;
  assign req_wr_ok = fc_legal && fc_r == FC_WRITE && rx_idx_r >= RQ_HDR
                  && cnt_r <= MAX_REGS;

  always_comb
  begin
    if (req_rd_ok)
      rsp_len = cnt_r[4:0] + RS_RD_HDR;
    else if (req_wr_ok)
      rsp_len = RS_WR_LEN;
    else
      rsp_len = RS_ERR_LEN;
  end

  // Response bytes are built on the fly from the captured request.
  always_comb
  begin
    rsp_byte = 8'hff;
    if (tx_idx_r == RQ_FC)
    begin
      if (req_rd_ok || req_wr_ok)
        rsp_byte = fc_r;
      else
        rsp_byte = fc_r | FC_ERR_FLAG;
    end
    else if (tx_idx_r < rsp_len)
    begin
      if (req_rd_ok)
      begin
        if (tx_idx_r == RS_B1)
          rsp_byte = cnt_r;
        else
          rsp_byte = mem_r[sa_r[4:0] + tx_idx_r - RS_RD_HDR];
      end
      else if (req_wr_ok)
      begin
        if (tx_idx_r == RS_B1)
          rsp_byte = sa_r;
        else if (tx_idx_r == RS_B2)
          rsp_byte = cnt_r;
      end
      else
        rsp_byte = ERR_CODE;
    end
    else if (tx_idx_r == rsp_len)
      rsp_byte = crc_r[7:0];
    else if (tx_idx_r == rsp_len + RS_B1)
      rsp_byte = crc_r[15:8];
  end

  // Bit engine: shift in on rising SCL, drive SDA after falling SCL.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      bitcnt_r <= 4'h0;
      ackph_r  <= 1'b0;
      nack_r   <= 1'b0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      sda_oe_r <= 1'b0;
    end
    else if (bus.start_det || bus.stop_det || tmo_hit)
    begin
      // A stop before the check bytes just ends the read cleanly.
      bitcnt_r <= 4'h0;
      ackph_r  <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (bus.scl_rise)
    begin
      if (!ackph_r)
      begin
        sh_r     <= {sh_r[6:0], bus.sda};
        bitcnt_r <= bitcnt_r + 4'h1;
      end
      else
        nack_r <= bus.sda;
    end
    else if (byte_done)
    begin
      ackph_r  <= 1'b1;
      sda_oe_r <= ack_now;
      if (xf_r == XF_ADDR)
        nack_r <= 1'b0;
    end
    else if (ack_fall)
    begin
      ackph_r  <= 1'b0;
      bitcnt_r <= 4'h0;
      if (load_tx)
      begin
        tx_r     <= {rsp_byte[6:0], 1'b0};
        sda_oe_r <= !rsp_byte[7];
      end
      else
        sda_oe_r <= 1'b0;
    end
    else if (bus.scl_fall && xf_r == XF_RD && !nack_r && bitcnt_r != 4'h0)
    begin
      tx_r     <= {tx_r[6:0], 1'b0};
      sda_oe_r <= !tx_r[7];
    end
  end

  // Transfer state: address, request capture and response fetch.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      xf_r      <= XF_IDLE;
      fc_r      <= 8'h00;
      sa_r      <= 8'h00;
      cnt_r     <= 8'h00;
      rx_idx_r  <= 5'h00;
      tx_idx_r  <= 5'h00;
      crc_r     <= CRC_INIT;
      rd_sent_r <= 1'b0;
    end
    else if (bus.stop_det || tmo_hit)
      xf_r <= XF_IDLE;
    else if (bus.start_det)
      xf_r <= XF_ADDR;
    else if (byte_done)
    begin
      case (xf_r)
        XF_ADDR:
        begin
          if (pwr_r == SN_AWAKE && addr_hit && addr_rd)
          begin
            xf_r      <= XF_RD;
            tx_idx_r  <= 5'h00;
            crc_r     <= CRC_INIT;
            rd_sent_r <= 1'b0;
          end
          else if (pwr_r == SN_AWAKE && addr_hit)
          begin
            xf_r     <= XF_WR;
            rx_idx_r <= 5'h00;
            fc_r     <= 8'h00;
          end
          else
            xf_r <= XF_SKIP;
        end
        XF_WR:
        begin
          if (rx_idx_r == RQ_FC)
            fc_r <= sh_r;
          else if (rx_idx_r == RQ_SA)
            sa_r <= sh_r;
          else if (rx_idx_r == RQ_CNT)
            cnt_r <= sh_r;
          if (rx_idx_r != IDX_MAX)
            rx_idx_r <= rx_idx_r + 5'h01;
        end
        default:
        begin
        end
      endcase
    end
    else if (ack_fall && load_tx)
    begin
      rd_sent_r <= 1'b1;
      if (tx_idx_r < rsp_len)
        crc_r <= crc_step;
      if (tx_idx_r != IDX_MAX)
        tx_idx_r <= tx_idx_r + 5'h01;
    end
  end

  // Host data lands in consecutive registers as each byte arrives.
  assign wr_data = byte_done && xf_r == XF_WR && req_wr_ok
                && {3'h0, rx_idx_r} < cnt_r + RQ_HDR_B;
  assign wr_idx  = sa_r[4:0] + rx_idx_r - RQ_HDR;

  genvar g;
  generate
    for (g = 0; g < REG_N; g++)
    begin : g_mem
      always_ff @(posedge clk or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
          mem_r[g] <= 8'h00;
        else if (meas_done && pwr_r == SN_MEAS && g == RH_HI)
          mem_r[g] <= meas_rh[15:8];
        else if (meas_done && pwr_r == SN_MEAS && g == RH_LO)
          mem_r[g] <= meas_rh[7:0];
        else if (meas_done && pwr_r == SN_MEAS && g == TP_HI)
          mem_r[g] <= meas_temp[15:8];
        else if (meas_done && pwr_r == SN_MEAS && g == TP_LO)
          mem_r[g] <= meas_temp[7:0];
        else if (wr_data && wr_idx == 5'(g))
          mem_r[g] <= sh_r;
      end
    end
  endgenerate

  // Power state: asleep until woken, measuring after each read that sent data.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pwr_r        <= SN_SLEEP;
      tmo_r        <= '0;
      meas_start_r <= 1'b0;
    end
    else
    begin
      meas_start_r <= 1'b0;
      case (pwr_r)
        SN_SLEEP:
        begin
          tmo_r <= '0;
          if (byte_done && xf_r == XF_ADDR && addr_hit && !addr_rd)
            pwr_r <= SN_AWAKE;
        end
        SN_AWAKE:
        begin
          tmo_r <= tmo_r + 1'b1;
          if (tmo_hit)
            pwr_r <= SN_SLEEP;
          else if (bus.stop_det && xf_r == XF_RD && rd_sent_r)
          begin
            // The acquisition result only shows in the next exchange.
            pwr_r        <= SN_MEAS;
            meas_start_r <= 1'b1;
          end
        end
        SN_MEAS:
        begin
          if (meas_done)
            pwr_r <= SN_SLEEP;
        end
        default:
          pwr_r <= SN_SLEEP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      awake_r <= 1'b0;
      sda_o_r <= 1'b0;
    end
    else
    begin
      awake_r <= pwr_r != SN_SLEEP;
      sda_o_r <= 1'b0;
    end
  end

  assign sda_o      = sda_o_r;
  assign sda_oe     = sda_oe_r;
  assign awake      = awake_r;
  assign meas_start = meas_start_r;
endmodule : ths_i2c_target
`default_nettype wire

// [verif/ths_host_model.sv]
// Bus controller model that wakes the sensor and runs frames on the pins.
`timescale 1ns/1ns
`default_nettype none
module ths_host_model
(
  input  wire logic clk,
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // SDA moves only while SCL is low, so the target never sees a false start.
  task automatic xbit(input logic b, output logic r);
    sda_low <= !b;
    wt(6);
    scl <= 1'b1;
    wt(6);
    r = sda_in;
    wt(6);
    scl <= 1'b0;
    wt(6);
  endtask : xbit

  task automatic start();
    sda_low <= 1'b0;
    wt(6);
    scl <= 1'b1;
    wt(12);
    sda_low <= 1'b1;
    wt(12);
    scl <= 1'b0;
    wt(6);
  endtask : start

  task automatic stop();
    sda_low <= 1'b1;
    wt(6);
    scl <= 1'b1;
    wt(12);
    sda_low <= 1'b0;
    wt(12);
  endtask : stop

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(v[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask : wbyte

  // The last byte of a read is refused so the target lets go of SDA.
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'b1, b[i]);
    xbit(last, r);
  endtask : rbyte
endmodule : ths_host_model
`default_nettype wire

// [verif/ths_i2c_target_assertions.sv]
// Concurrent checks on the ports of the sensor I2C target.
`timescale 1ns/1ns
`default_nettype none
module ths_i2c_target_assertions
  import ths_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = TMO_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic awake,
  input wire logic meas_start,
  input wire logic meas_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] awake_cnt_r;
  logic [7:0]  idle_cnt_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      awake_cnt_r <= 32'h0;
    else
      awake_cnt_r <= awake ? awake_cnt_r + 32'h1 : 32'h0;
  end

  // Saturates so a long quiet bus cannot wrap back to a small count.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      idle_cnt_r <= 8'h00;
    else if (!(scl_i && sda_i))
      idle_cnt_r <= 8'h00;
    else if (idle_cnt_r != 8'hff)
      idle_cnt_r <= idle_cnt_r + 8'h01;
  end

  a_asleep_silent: assert property (
    !awake && !$past(awake) |-> !sda_oe)
    else $error("SDA driven while asleep");
  a_drive_low_only: assert property (sda_oe |-> !sda_o)
    else $error("SDA driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("SDA drive changed while SCL high");
  a_oe_after_fall: assert property (
    $rose(sda_oe) |-> awake && !$past(scl_i, 2))
    else $error("SDA drive began outside SCL low");
  a_start_one_shot: assert property (
    meas_start |=> !meas_start [*8])
    else $error("acquisition started twice");
  a_start_on_stop: assert property (
    meas_start |-> scl_i && sda_i && $past(awake))
    else $error("acquisition started without a finished exchange");
  a_meas_keeps_awake: assert property (
    meas_start |=> awake [*8])
    else $error("slept during acquisition");
  a_sleep_after_meas: assert property (
    meas_start ##[1:60] meas_done |-> ##[1:3] !awake)
    else $error("no sleep after acquisition");
  a_wake_timeout: assert property (
    awake_cnt_r <= TMO_CYCLES + 8)
    else $error("stayed awake past the limit");
  a_no_self_wake: assert property (
    $rose(awake) |-> idle_cnt_r < 8'h28)
    else $error("woke without bus traffic");

  c_meas: cover property (meas_start);
  c_ack: cover property ($rose(sda_oe));
  c_timeout: cover property (awake_cnt_r == TMO_CYCLES);
  c_sleep: cover property (meas_done ##[1:3] !awake);
endmodule : ths_i2c_target_assertions
`default_nettype wire

bind ths_i2c_target ths_i2c_target_assertions #(.TMO_CYCLES(TMO_CYCLES))
  ths_i2c_target_assertions_inst (.clk(clk), .rst_n(rst_n), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .awake(awake),
  .meas_start(meas_start), .meas_done(meas_done));

// [verif/sensor_i2c_register_protocol_slave_bench.sv]
// Self-checking bench for the sensor I2C target.
`timescale 1ns/1ns
`default_nettype none
module sensor_i2c_register_protocol_slave_bench;
  localparam int unsigned TMO = 20000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        meas_done = 1'b0;
  logic [15:0] meas_rh = 16'h01f4;
  logic [15:0] meas_temp = 16'h00fa;
  logic [19:0] mpipe = 20'h0;
  int          n_meas = 0;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [7:0]  rsp[$];
  wire logic   scl, host_low, sda_o, sda_oe, awake, meas_start, sda;

  always #20 clk = ~clk;
  assign sda = !(host_low || (sda_oe && !sda_o));

  ths_i2c_target #(.TMO_CYCLES(TMO)) ths_i2c_target_inst (.clk(clk),
    .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .awake(awake), .meas_start(meas_start),
    .meas_done(meas_done), .meas_rh(meas_rh), .meas_temp(meas_temp));
  ths_host_model ths_host_model_inst (.clk(clk), .sda_in(sda), .scl(scl),
    .sda_low(host_low));

  // A short fixed conversion time stands in for the real acquisition.
  always @(posedge clk)
  begin
    mpipe <= {mpipe[18:0], meas_start};
    meas_done <= mpipe[19];
    if (meas_start === 1'b1)
      n_meas <= n_meas + 1;
  end

  task automatic chk(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc

  task automatic chk_rsp(input logic [7:0] e[$]);
    logic [15:0] c;
    c = crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    foreach (rsp[i])
      chk("response byte", e[i], rsp[i]);
  endtask : chk_rsp

  task automatic wake();
    logic a;
    ths_host_model_inst.start();
    ths_host_model_inst.wbyte(8'hb8, a);
    ths_host_model_inst.stop();
    chk("wake ack", 8'h00, {7'h0, a});
    chk("woken", 8'h01, {7'h0, awake});
  endtask : wake

  task automatic xact(input logic [7:0] req[$], input int nrd);
    logic       a;
    logic [7:0] b;
    int         n0;
    wake();
    ths_host_model_inst.start();
    ths_host_model_inst.wbyte(8'hb8, a);
    chk("address ack", 8'h01, {7'h0, a});
    foreach (req[i])
    begin
      ths_host_model_inst.wbyte(req[i], a);
      chk("request ack", 8'h01, {7'h0, a});
    end
    ths_host_model_inst.stop();
    n0 = n_meas;
    ths_host_model_inst.start();
    ths_host_model_inst.wbyte(8'hb9, a);
    chk("read ack", 8'h01, {7'h0, a});
    rsp = {};
    for (int i = 0; i < nrd; i++)
    begin
      ths_host_model_inst.rbyte(i == nrd - 1, b);
      rsp.push_back(b);
    end
    ths_host_model_inst.stop();
    repeat (40) @(posedge clk);
    chk("acquisitions", 8'h01, 8'(n_meas - n0));
    chk("asleep again", 8'h00, {7'h0, awake});
  endtask : xact

  task automatic t_addr_sleep();
    logic a;
    chk("asleep", 8'h00, {7'h0, awake});
    ths_host_model_inst.start();
    ths_host_model_inst.wbyte(8'hba, a);
    ths_host_model_inst.stop();
    chk("other address", 8'h00, {7'h0, a});
    chk("not woken", 8'h00, {7'h0, awake});
    wake();
    ths_host_model_inst.start();
    ths_host_model_inst.wbyte(8'h3a, a);
    ths_host_model_inst.stop();
    chk("other address", 8'h00, {7'h0, a});
    repeat (TMO) @(posedge clk);
    chk("timed out", 8'h00, {7'h0, awake});
    $display("test addr_sleep done");
  endtask : t_addr_sleep

  task automatic t_read();
    xact({8'h03, 8'h00, 8'h04}, 2);
    chk_rsp({8'h03, 8'h04});
    xact({8'h03, 8'h00, 8'h04}, 8);
    chk_rsp({8'h03, 8'h04, 8'h01, 8'hf4, 8'h00, 8'hfa});
    @(posedge clk);
    meas_rh <= 16'h0280;
    xact({8'h03, 8'h00, 8'h02}, 6);
    chk_rsp({8'h03, 8'h02, 8'h01, 8'hf4});
    xact({8'h03, 8'h00, 8'h01}, 5);
    chk_rsp({8'h03, 8'h01, 8'h02});
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    logic [7:0]  q[$];
    logic [15:0] c;
    q = {8'h10, 8'h10, 8'h02, 8'h01, 8'h02};
    c = crc(q);
    xact({q, c[7:0], c[15:8]}, 5);
    chk_rsp({8'h10, 8'h10, 8'h02});
    xact({8'h03, 8'h10, 8'h02}, 6);
    chk_rsp({8'h03, 8'h02, 8'h01, 8'h02});
    $display("test write done");
  endtask : t_write

  task automatic t_errors();
    xact({8'h03, 8'h00, 8'h0a}, 2);
    chk_rsp({8'h03, 8'h0a});
    xact({8'h03, 8'h00, 8'h0b}, 4);
    chk_rsp({8'h83, 8'h01});
    xact({8'h10, 8'h00, 8'h0b}, 4);
    chk_rsp({8'h90, 8'h01});
    xact({8'h03, 8'h00, 8'h00}, 4);
    chk_rsp({8'h83, 8'h01});
    xact({8'h00, 8'h00, 8'h01}, 4);
    chk_rsp({8'h80, 8'h01});
    $display("test errors done");
  endtask : t_errors

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_addr_sleep();
    t_read();
    t_write();
    t_errors();
    close_out();
  end

  // The tests need about 49,400 cycles; 80,000 keeps the run bounded.
  initial
  begin
    #3200000;
    miscompares++;
    close_out();
  end
endmodule : sensor_i2c_register_protocol_slave_bench
`default_nettype wire
